/* src/pmio_bcd.sv */
// Free-running binary to BCD converter (shift and add three).
// Assumes the input may change any time; each result is one coherent snapshot.
`timescale 1ns/1ps
`default_nettype none
module pmio_bcd import pmio_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Magnitude and sign in, digits out
  input wire logic [31:0] bin_i,
  input wire logic neg_i,
  output logic [4*BCD_DIGITS-1:0] bcd_o,
  output logic neg_o
);

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [4*BCD_DIGITS-1:0] acc;
    logic neg;
    logic [4*BCD_DIGITS-1:0] res;
    logic rneg;
  } pmio_bcd_state_t;

  pmio_bcd_state_t s_q, s_d;

  // One bit per cycle; a new conversion starts as soon as the last ends
  always_comb begin
    logic [4*BCD_DIGITS-1:0] adj;
    adj = s_q.acc;
    s_d = s_q;
    for (int i = 0; i < BCD_DIGITS; i++) begin
      if (adj[4*i+:4] > 4'h4) begin
        adj[4*i+:4] = adj[4*i+:4] + 4'h3;
      end
    end
    if (!s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt = 6'h00;
      s_d.sh = bin_i;
      s_d.acc = '0;
      s_d.neg = neg_i;
    end else begin
      s_d.acc = {adj[4*BCD_DIGITS-2:0], s_q.sh[31]};
      s_d.sh = {s_q.sh[30:0], 1'b0};
      s_d.cnt = s_q.cnt + 6'h01;
      if (s_q.cnt == 6'h1F) begin
        s_d.busy = 1'b0;
        s_d.res = {adj[4*BCD_DIGITS-2:0], s_q.sh[31]};
        s_d.rneg = s_q.neg;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bcd_o = s_q.res;
  assign neg_o = s_q.rneg;

endmodule
`default_nettype wire

/* src/pmio_pkg.sv */
// Shared constants and types of the panel monitor and I/O service block.
// Assumes a 25 MHz register clock and a 32-bit AXI4-Lite register bus.
package pmio_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MON = 8'h04;
  localparam logic [7:0] OFS_PARAM = 8'h08;
  localparam logic [7:0] OFS_PFMT = 8'h0C;
  localparam logic [7:0] OFS_OUTCFG = 8'h10;
  localparam logic [7:0] OFS_FORCED = 8'h14;
  localparam logic [7:0] OFS_FAULT_SEL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IO = 8'h20;
  localparam logic [7:0] OFS_DISP = 8'h24;
  localparam logic [7:0] OFS_FAULT_BASE = 8'h40;

  // Field positions
  localparam int CTRL_HEX_BIT = 0;
  localparam int CTRL_HIGH_BIT = 1;
  localparam int CTRL_VIEW_LSB = 4;
  localparam int PFMT_HEX_BIT = 0;
  localparam int PFMT_32_BIT = 1;

  // Values and reset values
  localparam logic [15:0] OUTCFG_FORCE_ON = 16'h0196;
  localparam logic [15:0] OUTCFG_FORCE_TOGGLE = 16'h0190;
  localparam logic [15:0] JOG_SPEED_RST = 16'h0014;
  localparam logic [15:0] JOG_SPEED_MAX = 16'h1388;

  // Sizes
  localparam int N_DI = 8;
  localparam int N_DO = 5;
  localparam int N_FAULT = 5;
  localparam int N_DIGIT = 5;
  localparam int BCD_DIGITS = 10;

  // Display character codes: 5'h00..5'h0F are the hex digits
  localparam logic [4:0] CH_BLANK = 5'h10;
  localparam logic [4:0] CH_HIGH = 5'h11;
  localparam logic [4:0] CH_LOW = 5'h12;

  typedef enum logic [2:0] {VIEW_MON, VIEW_PARAM, VIEW_FAULT, VIEW_JOG, VIEW_DI, VIEW_DO, VIEW_FORCED} pmio_view_t;
  typedef enum logic [1:0] {JOG_IDLE, JOG_EDIT, JOG_RUN} pmio_jog_t;

endpackage

/* src/pmio_sync.sv */
// Two-flop synchroniser for panel keys and drive pins, with a rise pulse.
// Assumes inputs are asynchronous to aclk; only the second and third stages feed logic.
`timescale 1ns/1ps
`default_nettype none
module pmio_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and synchronised results
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } pmio_sync_state_t;

  pmio_sync_state_t s_q, s_d;

  // Shift chain; the edge detector looks only at the second and third stages
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.sync;
  assign rise_o = s_q.sync & ~s_q.prev;

endmodule
`default_nettype wire

/* src/pmio_top.sv */
// Panel monitor and I/O service: display formatter, fault view, jog, forced outputs.
// Assumes keys and drive pins are asynchronous; func_out comes from logic on aclk.
// How it works
// - Decimal 16-bit shows five digits, leading zeros
// - Hex 16-bit shows four digits, no prefix
// - Decimal 32-bit splits five low, rest high
// - Hex 32-bit halves prefixed h and L
// - Negative decimal lights points; hex never
// - Same formatting for monitor and parameter views
// - Monitor value 32 bits, free half/format
// - Parameter format fixed, ignores operator hex selection
// - Set key shows selected stored fault code
// - Jog speed shown, default 20, keys adjust
// - Jog turns only while arrow key held
// - Jog motion only while servo is on
// - Writing 406 enables forced output control
// - Forced value bit n drives output n+1
// - Forced value lost at reset; outputs normal
// - Writing 400 toggles forced output mode
// - Forcing acts only while servo is off
// - Input view: bit0 input1 .. bit7 input8
// - Output view: bit0 output1 .. bit4 output5
// - Forced value hex view blanks fifth digit
`timescale 1ns/1ps
`default_nettype none
module pmio_top import pmio_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Panel keys and display
  input wire logic key_up_pin,
  input wire logic key_down_pin,
  input wire logic key_set_pin,
  input wire logic key_mode_pin,
  output logic [5*N_DIGIT-1:0] disp_char,
  output logic [N_DIGIT-1:0] disp_dp,
  // Drive side
  input wire logic servo_on_pin,
  input wire logic [N_DI-1:0] digital_input,
  input wire logic [N_DO-1:0] func_out,
  output logic [N_DO-1:0] digital_out,
  output logic jog_fwd,
  output logic jog_rev,
  output logic [15:0] jog_speed
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] mon;
    logic [31:0] param;
    logic [1:0] pfmt;
    logic [15:0] outcfg;
    logic [15:0] forced;
    logic [2:0] fault_sel;
    logic [N_FAULT-1:0][15:0] fault;
    logic force_en;
    logic fault_show;
    pmio_jog_t jog;
    logic [15:0] jog_speed;
    logic jog_fwd;
    logic jog_rev;
    logic [N_DO-1:0] dout;
    logic [5*N_DIGIT-1:0] disp;
    logic [N_DIGIT-1:0] dp;
  } pmio_state_t;

  pmio_state_t s_q, s_d;
  logic [12:0] pin_lvl, pin_rise;
  logic key_up, key_down, up_rise, down_rise, set_rise, mode_rise, servo_on;
  logic [N_DI-1:0] di;
  pmio_view_t view;
  logic [31:0] src_val, sval, mag;
  logic src_hex, src_32, src_high, neg;
  logic [4*BCD_DIGITS-1:0] bcd;
  logic bcd_neg;
  logic wr_fire;
  logic [31:0] wr_val;

  // All panel and drive pins cross into aclk through one synchroniser bank
  pmio_sync #(.W(13)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_i({digital_input, servo_on_pin, key_mode_pin, key_set_pin, key_down_pin, key_up_pin}),
    .level_o(pin_lvl),
    .rise_o(pin_rise)
  );

  assign key_up = pin_lvl[0];
  assign key_down = pin_lvl[1];
  assign up_rise = pin_rise[0];
  assign down_rise = pin_rise[1];
  assign set_rise = pin_rise[2];
  assign mode_rise = pin_rise[3];
  assign servo_on = pin_lvl[4];
  assign di = pin_lvl[12:5];
  assign view = pmio_view_t'(s_q.ctrl[CTRL_VIEW_LSB +: 3]);

  // Register read mux; returns zero for unmapped addresses
  function automatic logic [31:0] reg_read(input pmio_state_t s, input logic [AXI_ADDR_W-1:0] a,
                                            input logic [N_DI-1:0] din, input logic sv);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_CTRL: r = s.ctrl;
      OFS_MON: r = s.mon;
      OFS_PARAM: r = s.param;
      OFS_PFMT: r = {30'h0, s.pfmt};
      OFS_OUTCFG: r = {16'h0, s.outcfg};
      OFS_FORCED: r = {16'h0, s.forced};
      OFS_FAULT_SEL: r = {29'h0, s.fault_sel};
      OFS_STATUS: r = {s.jog_speed, 9'h0, s.fault_show, sv, s.force_en, s.jog_rev, s.jog_fwd, s.jog};
      OFS_IO: r = {19'h0, s.dout, din};
      OFS_DISP: r = {2'h0, s.dp, s.disp};
      default: begin
        for (int i = 0; i < N_FAULT; i++) begin
          if (a == OFS_FAULT_BASE + 8'(4 * i)) begin
            r = {16'h0, s.fault[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] a);
    logic h;
    h = (a <= OFS_DISP) && (a[1:0] == 2'h0);
    for (int i = 0; i < N_FAULT; i++) begin
      h = h | (a == OFS_FAULT_BASE + 8'(4 * i));
    end
    return h;
  endfunction

  // Byte lanes not strobed keep their old contents
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  always_comb begin
    wr_val = reg_read(s_q, s_q.waddr, di, servo_on);
    for (int b = 0; b < 4; b++) begin
      if (s_q.wstrb[b]) begin
        wr_val[8*b+:8] = s_q.wdata[8*b+:8];
      end
    end
  end

  // Source and format of the shown value; parameters use their own fixed format
  always_comb begin
    src_val = s_q.mon;
    src_hex = s_q.ctrl[CTRL_HEX_BIT];
    src_32 = 1'b1;
    src_high = s_q.ctrl[CTRL_HIGH_BIT];
    unique case (view)
      VIEW_MON: src_32 = 1'b1;
      VIEW_PARAM: begin
        src_val = s_q.param;
        src_hex = s_q.pfmt[PFMT_HEX_BIT];
        src_32 = s_q.pfmt[PFMT_32_BIT];
      end
      VIEW_FAULT: begin
        src_val = s_q.fault_show ? {16'h0, s_q.fault[s_q.fault_sel]} : {29'h0, s_q.fault_sel} + 32'h1;
        src_hex = s_q.fault_show;
        src_32 = 1'b0;
      end
      VIEW_JOG: begin
        src_val = {16'h0, s_q.jog_speed};
        src_hex = 1'b0;
        src_32 = 1'b0;
      end
      VIEW_DI: begin
        src_val = {24'h0, di};
        src_hex = 1'b1;
        src_32 = 1'b0;
      end
      VIEW_DO: begin
        src_val = {27'h0, s_q.dout};
        src_hex = 1'b1;
        src_32 = 1'b0;
      end
      VIEW_FORCED: begin
        src_val = {16'h0, s_q.forced};
        src_hex = 1'b1;
        src_32 = 1'b0;
      end
      default: src_val = s_q.mon;
    endcase
  end

  // 16-bit values are signed in their own width; hex never counts as negative
  assign sval = src_32 ? src_val : {{16{src_val[15]}}, src_val[15:0]};
  assign neg = !src_hex && sval[31];
  assign mag = neg ? 32'h0 - sval : sval;

  pmio_bcd u_bcd (
    .aclk(aclk),
    .aresetn(aresetn),
    .bin_i(mag),
    .neg_i(neg),
    .bcd_o(bcd),
    .neg_o(bcd_neg)
  );

  // Next state: bus slave, registers, jog, outputs and display
  always_comb begin
    logic [BCD_DIGITS-1:0] sig;
    logic any;
    int base;
    sig = '0;
    any = 1'b0;
    base = 0;
    s_d = s_q;
    // Address and data are taken independently; the write lands once both are in
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.waddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_hit(s_q.waddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.waddr)
        OFS_CTRL: s_d.ctrl = wr_val;
        OFS_MON: s_d.mon = wr_val;
        OFS_PARAM: s_d.param = wr_val;
        OFS_PFMT: s_d.pfmt = wr_val[1:0];
        OFS_OUTCFG: begin
          s_d.outcfg = wr_val[15:0];
          if (wr_val[15:0] == OUTCFG_FORCE_ON) begin
            s_d.force_en = 1'b1;
          end else if (wr_val[15:0] == OUTCFG_FORCE_TOGGLE) begin
            s_d.force_en = !s_q.force_en;
          end
        end
        OFS_FORCED: s_d.forced = wr_val[15:0];
        OFS_FAULT_SEL: s_d.fault_sel = (wr_val[2:0] < 3'(N_FAULT)) ? wr_val[2:0] : 3'h0;
        default: begin
          for (int i = 0; i < N_FAULT; i++) begin
            if (s_q.waddr == OFS_FAULT_BASE + 8'(4 * i)) begin
              s_d.fault[i] = wr_val[15:0];
            end
          end
        end
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    // Reads answer one cycle after the address is taken
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = reg_read(s_q, araddr, di, servo_on);
      s_d.rresp = addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;
    // Fault entry: set key flips between index and stored code
    if (view != VIEW_FAULT) begin
      s_d.fault_show = 1'b0;
    end else if (set_rise) begin
      s_d.fault_show = !s_q.fault_show;
    end
    // Jog sequence: set enters speed edit, set confirms, mode returns to edit
    unique case (s_q.jog)
      JOG_IDLE: if (set_rise) s_d.jog = JOG_EDIT;
      JOG_EDIT: begin
        if (up_rise && s_q.jog_speed < JOG_SPEED_MAX) begin
          s_d.jog_speed = s_q.jog_speed + 16'h0001;
        end else if (down_rise && s_q.jog_speed != 16'h0000) begin
          s_d.jog_speed = s_q.jog_speed - 16'h0001;
        end
        if (set_rise) s_d.jog = JOG_RUN;
      end
      JOG_RUN: if (mode_rise) s_d.jog = JOG_EDIT;
    endcase
    if (view != VIEW_JOG) begin
      s_d.jog = JOG_IDLE;
    end
    // Motion only while one arrow is held and the drive is enabled
    s_d.jog_fwd = (s_q.jog == JOG_RUN) && servo_on && key_up && !key_down;
    s_d.jog_rev = (s_q.jog == JOG_RUN) && servo_on && key_down && !key_up;
    // Forcing overrides the functions only with the drive disabled
    s_d.dout = (s_q.force_en && !servo_on) ? s_q.forced[N_DO-1:0] : func_out;
    // Display: significance marks digits at or below the leading non-zero one
    for (int j = BCD_DIGITS - 1; j >= 0; j--) begin
      any = any | (bcd[4*j+:4] != 4'h0);
      sig[j] = any;
    end
    base = (src_32 && src_high) ? N_DIGIT : 0;
    for (int i = 0; i < N_DIGIT; i++) begin
      if (src_hex) begin
        s_d.disp[5*i+:5] = {1'b0, src_val[(src_32 && src_high ? 16 : 0) + 4*i +: 4]};
        s_d.dp[i] = 1'b0;
      end else begin
        s_d.disp[5*i+:5] = {1'b0, bcd[4*(base+i)+:4]};
        s_d.dp[i] = bcd_neg && sig[base+i];
      end
    end
    if (src_hex) begin
      s_d.disp[5*(N_DIGIT-1)+:5] = !src_32 ? CH_BLANK : (src_high ? CH_HIGH : CH_LOW);
    end else if (src_32 && src_high) begin
      s_d.dp[0] = 1'b1;
    end
  end

  // Sync reset; forced value and force mode are never kept over it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.jog_speed <= JOG_SPEED_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign disp_char = s_q.disp;
  assign disp_dp = s_q.dp;
  assign digital_out = s_q.dout;
  assign jog_fwd = s_q.jog_fwd;
  assign jog_rev = s_q.jog_rev;
  assign jog_speed = s_q.jog_speed;

  // Checks
  property p_normal_out;
    @(posedge aclk) disable iff (!aresetn) servo_on |=> digital_out == $past(func_out);
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("outputs not function-driven with servo on");

  property p_forced_out;
    @(posedge aclk) disable iff (!aresetn) (s_q.force_en && !servo_on) |=> digital_out == $past(s_q.forced[N_DO-1:0]);
  endproperty
  a_forced_out: assert property (p_forced_out) else $error("forced mask not on outputs");

  property p_force_on;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && s_q.waddr == OFS_OUTCFG && wr_val[15:0] == OUTCFG_FORCE_ON) |=> s_q.force_en;
  endproperty
  a_force_on: assert property (p_force_on) else $error("406 did not enable forcing");

  property p_force_toggle;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && s_q.waddr == OFS_OUTCFG && wr_val[15:0] == OUTCFG_FORCE_TOGGLE) |=> s_q.force_en != $past(s_q.force_en);
  endproperty
  a_force_toggle: assert property (p_force_toggle) else $error("400 did not switch forcing");

  property p_reset_clear;
    @(posedge aclk) !aresetn |=> (!s_q.force_en && s_q.forced == 16'h0000 && s_q.jog_speed == JOG_SPEED_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left forcing or jog speed");

  property p_jog_servo;
    @(posedge aclk) disable iff (!aresetn) !servo_on |=> !jog_fwd && !jog_rev;
  endproperty
  a_jog_servo: assert property (p_jog_servo) else $error("jog moved with servo off");

  property p_jog_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.jog == JOG_RUN && servo_on && key_up && !key_down) |=> jog_fwd;
  endproperty
  a_jog_hold: assert property (p_jog_hold) else $error("jog not tied to held key");

  // Releasing the arrow must stop motion on the next cycle
  property p_jog_release;
    @(posedge aclk) disable iff (!aresetn) !key_up |=> !jog_fwd;
  endproperty
  a_jog_release: assert property (p_jog_release) else $error("jog kept turning after release");

  property p_di_view;
    @(posedge aclk) disable iff (!aresetn)
      view == VIEW_DI |=> (disp_char[9:0] == {1'b0, $past(di[7:4]), 1'b0, $past(di[3:0])}) && disp_dp == 5'h00;
  endproperty
  a_di_view: assert property (p_di_view) else $error("input view bits wrong");

  property p_hex16_blank;
    @(posedge aclk) disable iff (!aresetn) (view == VIEW_FORCED || view == VIEW_DO) |=> disp_char[24:20] == CH_BLANK;
  endproperty
  a_hex16_blank: assert property (p_hex16_blank) else $error("fifth digit not blank in hex view");

  property p_param_fixed;
    @(posedge aclk) disable iff (!aresetn) (view == VIEW_PARAM && !s_q.pfmt[PFMT_HEX_BIT]) |=> disp_char[24:20] < 5'h0A;
  endproperty
  a_param_fixed: assert property (p_param_fixed) else $error("parameter format changed by selection");

  c_jog_run: cover property (@(posedge aclk) disable iff (!aresetn) jog_fwd ##[1:20] jog_rev);
  c_forced: cover property (@(posedge aclk) disable iff (!aresetn) s_q.force_en && !servo_on && digital_out != func_out);
  c_neg_dec: cover property (@(posedge aclk) disable iff (!aresetn) disp_dp != 5'h00 && view == VIEW_MON);

endmodule
`default_nettype wire

/* tb/pmio_panel.sv */
// Keypad model of the front panel: an operator pressing and releasing keys.
// Assumes aclk from the bench; keys move just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pmio_panel (
  // Clock
  input wire logic aclk,
  // Keys, pressed is high
  output logic key_up,
  output logic key_down,
  output logic key_set,
  output logic key_mode
);
  // Key levels: up, down, set, mode
  logic [3:0] k_q = 4'h0;
  assign {key_mode, key_set, key_down, key_up} = k_q;
  // Hold long enough for the two-flop synchroniser and one output stage
  task automatic hold(input int k, input logic v);
    @(posedge aclk);
    k_q[k] <= v;
    repeat (5) @(posedge aclk);
  endtask
  // One press and release
  task automatic tap(input int k);
    hold(k, 1'b1);
    hold(k, 1'b0);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench: register bus tasks, panel keys and drive pins checked against expected values.
// Assumes pmio_panel as keypad; protection is tied, byte strobes are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmio_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic servo = 1'b0;
  logic [7:0] din = 8'hE1;
  logic [4:0] fout = 5'h1A;
  logic [3:0] wstb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, jfwd, jrev, ku, kd, ks, km;
  logic [1:0] bresp, rresp, rrsp, brsp;
  logic [31:0] rdata, rdat;
  logic [24:0] dch;
  logic [4:0] ddp, dout;
  logic [15:0] jspd;
  int n_mismatch = 0;
  int num_checks = 0;
  always #20 aclk = ~aclk;
  pmio_top dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .key_up_pin(ku), .key_down_pin(kd),
    .key_set_pin(ks), .key_mode_pin(km), .disp_char(dch), .disp_dp(ddp), .servo_on_pin(servo),
    .digital_input(din), .func_out(fout), .digital_out(dout), .jog_fwd(jfwd), .jog_rev(jrev), .jog_speed(jspd)
  );
  pmio_panel u_pnl (.aclk(aclk), .key_up(ku), .key_down(kd), .key_set(ks), .key_mode(km));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic tmo();
    n_mismatch++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    brsp = bresp;
    bready <= 1'b0;
    if (i == 50) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
    if (i == 50) tmo();
  endtask
  // Expected display word: points, leftmost code, four nibble digits
  function automatic logic [31:0] ex(input logic [4:0] p, input logic [4:0] c, input logic [15:0] h);
    return {2'h0, p, c, 1'b0, h[15:12], 1'b0, h[11:8], 1'b0, h[7:4], 1'b0, h[3:0]};
  endfunction
  // Decimal digits come from a slow snapshot, hence the long settle
  task automatic dsp(input logic [31:0] c, input logic [31:0] e);
    wr(OFS_CTRL, c);
    repeat (70) @(posedge aclk);
    chk({2'h0, ddp, dch}, e);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    chk({11'h0, dout, jspd}, 32'h00000014);
    aresetn <= 1'b1;
    wr(OFS_MON, 32'h499602D2);
    dsp(32'h00, ex(5'h00, 5'h06, 16'h7890));
    dsp(32'h02, ex(5'h01, 5'h01, 16'h2345));
    dsp(32'h01, ex(5'h00, CH_LOW, 16'h02D2));
    dsp(32'h03, ex(5'h00, CH_HIGH, 16'h4996));
    wr(OFS_MON, 32'hFFFFCFC7);
    dsp(32'h00, ex(5'h1F, 5'h01, 16'h2345));
    dsp(32'h01, ex(5'h00, CH_LOW, 16'hCFC7));
    $display("test monitor done");
    wr(OFS_PARAM, 32'h04D2);
    wr(OFS_PFMT, 32'h0);
    dsp(32'h11, ex(5'h00, 5'h00, 16'h1234));
    wr(OFS_PARAM, 32'hCFC7);
    dsp(32'h10, ex(5'h1F, 5'h01, 16'h2345));
    wr(OFS_PARAM, 32'h1234);
    wr(OFS_PFMT, 32'h1);
    dsp(32'h10, ex(5'h00, CH_BLANK, 16'h1234));
    $display("test parameter done");
    wr(OFS_FAULT_BASE + 8'h08, 32'h0ABC);
    wr(OFS_FAULT_SEL, 32'h2);
    wr(OFS_CTRL, 32'h20);
    u_pnl.tap(2);
    chk({12'h0, dch[19:0]}, ex(5'h00, 5'h00, 16'h0ABC) & 32'h000FFFFF);
    $display("test fault done");
    servo <= 1'b1;
    wr(OFS_CTRL, 32'h30);
    u_pnl.tap(2);
    u_pnl.tap(0);
    u_pnl.tap(0);
    u_pnl.tap(2);
    chk({16'h0, jspd}, 32'h16);
    u_pnl.hold(0, 1'b1);
    chk({jfwd, jrev}, 2'b10);
    u_pnl.hold(0, 1'b0);
    chk({jfwd, jrev}, 2'b00);
    u_pnl.hold(1, 1'b1);
    chk({jfwd, jrev}, 2'b01);
    u_pnl.hold(1, 1'b0);
    servo <= 1'b0;
    u_pnl.hold(0, 1'b1);
    chk({jfwd, jrev}, 2'b00);
    u_pnl.hold(0, 1'b0);
    u_pnl.tap(3);
    u_pnl.tap(1);
    chk({16'h0, jspd}, 32'h15);
    $display("test jog done");
    wr(OFS_OUTCFG, 32'h0196);
    wr(OFS_FORCED, 32'h5);
    repeat (3) @(posedge aclk);
    chk(dout, 5'h05);
    wr(OFS_FORCED, 32'hFFE2);
    repeat (3) @(posedge aclk);
    chk(dout, 5'h02);
    // Only byte lane 1 is written; lane 0 keeps its old contents
    wstb <= 4'h2;
    wr(OFS_FORCED, 32'h00000005);
    wstb <= 4'hF;
    rd(OFS_FORCED);
    chk(rdat, 32'h000000E2);
    chk(dout, 5'h02);
    servo <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(dout, 5'h1A);
    servo <= 1'b0;
    wr(OFS_OUTCFG, 32'h0190);
    repeat (5) @(posedge aclk);
    chk(dout, 5'h1A);
    wr(OFS_OUTCFG, 32'h0190);
    repeat (3) @(posedge aclk);
    chk(dout, 5'h02);
    wr(OFS_CTRL, 32'h60);
    repeat (3) @(posedge aclk);
    chk({2'h0, ddp, dch}, ex(5'h00, CH_BLANK, 16'h00E2));
    wr(OFS_CTRL, 32'h50);
    repeat (3) @(posedge aclk);
    chk({2'h0, ddp, dch}, ex(5'h00, CH_BLANK, 16'h0002));
    rd(OFS_IO);
    chk(rdat & 32'h1FFF, {19'h0, 5'h02, 8'hE1});
    din <= 8'h3C;
    wr(OFS_CTRL, 32'h40);
    repeat (3) @(posedge aclk);
    chk({2'h0, ddp, dch}, ex(5'h00, CH_BLANK, 16'h003C));
    fout <= 5'h15;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({11'h0, dout, jspd}, {11'h0, 5'h15, 16'h0014});
    rd(8'h3C);
    chk({rrsp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h3C, 32'h1);
    chk({30'h0, brsp}, {30'h0, RESP_SLVERR});
    $display("test outputs done");
    finish_test();
  end
endmodule
`default_nettype wire
